// file: bench/amcgr_ext_clk_model.sv
// free running external modulator clock source that drives the clock pin
`timescale 1ns/1ps
module amcgr_ext_clk_model #(
    parameter real HALF_SLOW_NS = 6510.4,
    parameter real HALF_FAST_NS = 3255.2
) (
    input wire logic fast,
    output logic extClk
);
    // a master clock runs free, so there is no framing to stop it
    // slow is 76.8 kHz fast is 153.6 kHz
    initial extClk = 1'b0;
    always begin
        #(fast ? HALF_FAST_NS : HALF_SLOW_NS);
        extClk = ~extClk;
    end
endmodule

// file: bench/amcgr_registers_tb.sv
// self-checking bench for the converter mode, clock and pin control registers
`timescale 1ns/1ps
module amcgr_registers_tb;
    logic mclk, sys_rst, regWrEn, regRdEn, syncPin, extClkIn, extFast;
    logic clkPinOut, clkPinOe, filterReset, standbyActive;
    logic [3:0] regAddr, gpioOut, gpioOe;
    logic [15:0] regWrData, regRdData, modResult;
    int err_count = 0;
    int n_tests = 0;
    logic [7:0] pat [4] = '{8'h5a, 8'ha5, 8'hf3, 8'hcc};

    amcgr_registers uut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .syncPin(syncPin), .extClkIn(extClkIn),
        .modResult(modResult), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .filterReset(filterReset),
        .standbyActive(standbyActive));
    amcgr_ext_clk_model ext (.fast(extFast), .extClk(extClkIn));

    always #25 mclk = ~mclk;

    task automatic end_sim();
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // strobe is lowered and one edge passes, so back to back calls never clash
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, exp);
        @(posedge mclk);
    endtask

    // write then read with no gap between the strobes
    task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
        rd(a, d);
    endtask

    // outputs are read at the edge, before that edge's own updates land
    task automatic wait_conv(input logic v, output int n);
        n = 0;
        while (filterReset !== v) begin
            @(posedge mclk);
            n++;
            if (n > 20000) begin
                err_count++;
                $display("mismatch at %0t: sequencer wait ran out", $time);
                end_sim();
            end
        end
    endtask

    task automatic run_seq(input logic [3:0] mode, input logic [1:0] sel,
                           input logic [15:0] res);
        int n;
        logic c;
        extFast <= (sel == 2'b11);
        modResult <= res;
        wr_rd(amcgr_pkg::ADDR_CONV_CONTROL, {10'h000, mode, sel});
        chk({15'h0, clkPinOe}, {15'h0, sel == 2'b01});
        c = clkPinOut;
        repeat (130) @(posedge mclk);
        chk({15'h0, clkPinOut ^ c}, {15'h0, sel == 2'b01});
        chk({15'h0, filterReset}, 16'h0001);
        syncPin <= 1'b0;
        wait_conv(1'b0, n);
        syncPin <= 1'b1;
        wait_conv(1'b1, n);
        // sixteen ticks of a 76.8 kHz clock, about 4166 cycles
        chk({15'h0, n > 3850 && n < 4450}, 16'h0001);
        repeat (4) @(posedge mclk);
        chk({15'h0, standbyActive}, {15'h0, mode == 4'hb});
        chk({15'h0, gpioOut[1]}, 16'h0001);
        rd(amcgr_pkg::ADDR_AUX_CONTROL, {12'h000, 1'b1, mode == 4'hb, 2'b10});
        rd(amcgr_pkg::ADDR_RESULT, res);
        repeat (300) @(posedge mclk);
        chk({15'h0, filterReset}, 16'h0001);
        chk({15'h0, gpioOut[1]}, 16'h0000);
    endtask

    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        regAddr = 4'h0;
        regWrData = 16'h0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        syncPin = 1'b1;
        extFast = 1'b0;
        modResult = 16'h0000;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk({12'h0, gpioOe}, 16'h0000);
        chk({14'h0, clkPinOe, filterReset}, 16'h0001);
        rd(amcgr_pkg::ADDR_CONV_CONTROL, 16'h0000);
        rd(amcgr_pkg::ADDR_RESULT, 16'h0000);
        rd(amcgr_pkg::ADDR_IO_CONTROL, 16'h0000);
        rd(4'h7, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(amcgr_pkg::ADDR_IO_CONTROL, {8'hff, pat[i]});
            rd(amcgr_pkg::ADDR_IO_CONTROL, {8'h00, pat[i]});
            chk({12'h0, gpioOe}, {12'h0, pat[i][3:0]});
            chk({12'h0, gpioOut & gpioOe}, {12'h0, pat[i][7:4] & pat[i][3:0]});
        end
        // pin four set as a low output so the standby override is visible
        wr(amcgr_pkg::ADDR_IO_CONTROL, 16'h0008);
        wr(amcgr_pkg::ADDR_AUX_CONTROL, 16'h0003);
        wr(amcgr_pkg::ADDR_CONV_CONTROL, {10'h000, amcgr_pkg::MODE_STANDBY, 2'b00});
        repeat (6) @(posedge mclk);
        chk({12'h0, gpioOe & 4'ha}, 16'h000a);
        chk({14'h0, gpioOut[3], standbyActive}, 16'h0003);
        // now a high output, so only the override can pull it low
        wr(amcgr_pkg::ADDR_IO_CONTROL, 16'h0088);
        wr(amcgr_pkg::ADDR_CONV_CONTROL, {10'h000, amcgr_pkg::MODE_IDLE, 2'b00});
        repeat (6) @(posedge mclk);
        chk({14'h0, gpioOut[3], standbyActive}, 16'h0000);
        // interrupt pin stays selected so each sequence shows on it
        wr(amcgr_pkg::ADDR_AUX_CONTROL, 16'h0002);
        wr(amcgr_pkg::ADDR_IO_CONTROL, 16'h0000);
        run_seq(amcgr_pkg::MODE_SYNC_IDLE, 2'b00, 16'h1234);
        run_seq(amcgr_pkg::MODE_SYNC_STBY, 2'b01, 16'hfedc);
        run_seq(amcgr_pkg::MODE_SYNC_IDLE, 2'b10, 16'h8001);
        run_seq(amcgr_pkg::MODE_SYNC_STBY, 2'b11, 16'h7ffe);
        wr(amcgr_pkg::ADDR_RESULT, 16'h5555);
        rd(amcgr_pkg::ADDR_RESULT, 16'h7ffe);
        end_sim();
    end
endmodule

// file: verilog/amcgr_clk_gen.sv
// modulator clock source selection and internal oscillator divider
`timescale 1ns/1ps
module amcgr_clk_gen (
    input wire logic mclk,
    input wire logic sysRst,
    input wire logic extClkIn,
    amcgr_core_if.clkgen cif
);
    logic [7:0] oscCnt_r, oscCnt_nxt;
    logic oscLvl_r, oscLvl_nxt;
    logic extPrev_r, extPrev_nxt;
    logic extDiv_r, extDiv_nxt;
    logic tick_r, tick_nxt;
    logic oscRise;
    logic extRise;

    always_comb begin
        oscCnt_nxt = oscCnt_r + 8'h01;
        oscLvl_nxt = oscLvl_r;
        oscRise = 1'b0;
        if (oscCnt_r == amcgr_pkg::INT_OSC_HALF_CYC - 8'h01) begin
            oscCnt_nxt = 8'h00;
            oscLvl_nxt = ~oscLvl_r;
            oscRise = ~oscLvl_r;
        end
        extPrev_nxt = extClkIn;
        extRise = extClkIn & ~extPrev_r;
        extDiv_nxt = extDiv_r ^ extRise;
        case (cif.clkSel)
            amcgr_pkg::CLK_INT_OFF, amcgr_pkg::CLK_INT_OUT: tick_nxt = oscRise;
            amcgr_pkg::CLK_EXT: tick_nxt = extRise;
            amcgr_pkg::CLK_EXT_DIV2: tick_nxt = extRise & extDiv_r;
            default: tick_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sysRst) begin
            oscCnt_r <= 8'h00;
            oscLvl_r <= 1'b0;
            extPrev_r <= 1'b0;
            extDiv_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            oscCnt_r <= oscCnt_nxt;
            oscLvl_r <= oscLvl_nxt;
            extPrev_r <= extPrev_nxt;
            extDiv_r <= extDiv_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign cif.modTick = tick_r;
    assign cif.intClkLvl = oscLvl_r;

    property p_div_skip;
        @(posedge mclk) disable iff (sysRst)
        (cif.clkSel == amcgr_pkg::CLK_EXT_DIV2 && extRise && !extDiv_r) |=> !tick_r;
    endproperty
    a_div_skip: assert property (p_div_skip) else $error("divide by two passed an edge");
endmodule

// file: verilog/amcgr_core_if.sv
// signals shared between the register top, the clock selector and the sequencer
`timescale 1ns/1ps
interface amcgr_core_if;
    amcgr_pkg::amcgr_clksel_t clkSel;
    logic [3:0] mode;
    logic modTick;
    logic intClkLvl;
    amcgr_pkg::amcgr_state_t state;
    logic resultLoad;
    logic filterHold;

    modport clkgen (input clkSel, output modTick, output intClkLvl);
    modport seq (input mode, input modTick, output state, output resultLoad, output filterHold);
    modport top (output clkSel, output mode, input modTick, input intClkLvl, input state,
                 input resultLoad, input filterHold);
endinterface

// file: verilog/amcgr_pkg.sv
// shared constants and types for the converter mode, clock and pin control registers
package amcgr_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] ADDR_CONV_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_RESULT = 4'h2;
    localparam logic [3:0] ADDR_IO_CONTROL = 4'h3;
    localparam logic [3:0] ADDR_AUX_CONTROL = 4'h8;

    // values after reset
    localparam logic [5:0] CONV_CONTROL_RST = 6'h00;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [7:0] IO_CONTROL_RST = 8'h00;
    localparam logic [1:0] AUX_CONTROL_RST = 2'h0;

    // field positions
    localparam int CLKSEL_LSB = 0;
    localparam int MODE_LSB = 2;
    localparam int IO_DIR_LSB = 0;
    localparam int IO_DATA_LSB = 4;
    localparam int AUX_STBY_BIT = 0;
    localparam int AUX_INTSEL_BIT = 1;
    localparam int PIN_STBY = 3;
    localparam int PIN_INT = 1;

    typedef enum logic [1:0] {
        CLK_INT_OFF = 2'b00,
        CLK_INT_OUT = 2'b01,
        CLK_EXT = 2'b10,
        CLK_EXT_DIV2 = 2'b11
    } amcgr_clksel_t;

    localparam logic [3:0] MODE_STANDBY = 4'h2;
    localparam logic [3:0] MODE_IDLE = 4'h4;
    localparam logic [3:0] MODE_SYNC_IDLE = 4'ha;
    localparam logic [3:0] MODE_SYNC_STBY = 4'hb;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STANDBY = 2'b01,
        ST_CONVERT = 2'b10
    } amcgr_state_t;

    // internal oscillator in hertz, system clock in hertz
    localparam int INT_OSC_HZ = 76800;
    localparam int MCLK_HZ = 20000000;
    localparam logic [7:0] INT_OSC_HALF_CYC = 8'(MCLK_HZ / (2 * INT_OSC_HZ));
    // modulator clock periods per converted sequence
    localparam logic [7:0] CONV_TICKS = 8'h10;
endpackage

// file: verilog/amcgr_registers.sv
// register bank for converter mode, clock selection, result and shared pin control
`timescale 1ns/1ps
module amcgr_registers (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [15:0] regRdData,
    input wire logic syncPin,
    input wire logic extClkIn,
    input wire logic [15:0] modResult,
    output logic clkPinOut,
    output logic clkPinOe,
    output logic [3:0] gpioOut,
    output logic [3:0] gpioOe,
    output logic filterReset,
    output logic standbyActive
);
    amcgr_core_if cif ();

    amcgr_clk_gen uClkGen (
        .mclk(mclk),
        .sysRst(sys_rst),
        .extClkIn(extClkIn),
        .cif(cif)
    );

    amcgr_seq uSeq (
        .mclk(mclk),
        .sysRst(sys_rst),
        .syncPinIn(syncPin),
        .cif(cif)
    );

    logic [5:0] convCtrl_r, convCtrl_nxt;
    logic [15:0] result_r, result_nxt;
    logic [7:0] ioCtrl_r, ioCtrl_nxt;
    logic [1:0] auxCtrl_r, auxCtrl_nxt;
    logic ready_r, ready_nxt;
    logic [15:0] rdData_r, rdData_nxt;
    logic [3:0] gpioOut_r, gpioOut_nxt;
    logic [3:0] gpioOe_r, gpioOe_nxt;
    logic clkOut_r, clkOut_nxt;
    logic clkOe_r, clkOe_nxt;
    logic filtRst_r, filtRst_nxt;
    logic stby_r, stby_nxt;

    function automatic logic hit(input logic strobe, input logic [3:0] addr,
                                 input logic [3:0] target);
        hit = strobe && (addr == target);
    endfunction

    assign cif.clkSel = amcgr_pkg::amcgr_clksel_t'(convCtrl_r[amcgr_pkg::CLKSEL_LSB +: 2]);
    assign cif.mode = convCtrl_r[amcgr_pkg::MODE_LSB +: 4];

    // register contents
    always_comb begin
        convCtrl_nxt = convCtrl_r;
        ioCtrl_nxt = ioCtrl_r;
        auxCtrl_nxt = auxCtrl_r;
        result_nxt = result_r;
        ready_nxt = ready_r;
        if (hit(regWrEn, regAddr, amcgr_pkg::ADDR_CONV_CONTROL)) begin
            convCtrl_nxt = regWrData[5:0];
        end
        if (hit(regWrEn, regAddr, amcgr_pkg::ADDR_IO_CONTROL)) begin
            ioCtrl_nxt = regWrData[7:0];
        end
        if (hit(regWrEn, regAddr, amcgr_pkg::ADDR_AUX_CONTROL)) begin
            auxCtrl_nxt = regWrData[1:0];
        end
        // writes to the result offset are dropped; only the sequencer loads it
        if (cif.resultLoad) begin
            result_nxt = modResult;
        end
        // a result landing in the same cycle as its read keeps the flag set
        if (cif.resultLoad) begin
            ready_nxt = 1'b1;
        end else if (hit(regRdEn, regAddr, amcgr_pkg::ADDR_RESULT)) begin
            ready_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            convCtrl_r <= amcgr_pkg::CONV_CONTROL_RST;
            result_r <= amcgr_pkg::RESULT_RST;
            ioCtrl_r <= amcgr_pkg::IO_CONTROL_RST;
            auxCtrl_r <= amcgr_pkg::AUX_CONTROL_RST;
            ready_r <= 1'b0;
        end else begin
            convCtrl_r <= convCtrl_nxt;
            result_r <= result_nxt;
            ioCtrl_r <= ioCtrl_nxt;
            auxCtrl_r <= auxCtrl_nxt;
            ready_r <= ready_nxt;
        end
    end

    // read data stand for one cycle only, zero otherwise
    always_comb begin
        rdData_nxt = 16'h0000;
        if (regRdEn) begin
            case (regAddr)
                amcgr_pkg::ADDR_CONV_CONTROL: rdData_nxt = {10'h000, convCtrl_r};
                amcgr_pkg::ADDR_RESULT: rdData_nxt = result_r;
                amcgr_pkg::ADDR_IO_CONTROL: rdData_nxt = {8'h00, ioCtrl_r};
                amcgr_pkg::ADDR_AUX_CONTROL: rdData_nxt = {12'h000, ready_r, stby_r, auxCtrl_r};
                default: rdData_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdData_r <= 16'h0000;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    logic [3:0] pinOeBase;
    logic [3:0] pinOutBase;

    // a pin drives its data bit only while its direction bit selects output
    for (genvar g = 0; g < 4; g++) begin : gen_pin
        assign pinOeBase[g] = ioCtrl_r[amcgr_pkg::IO_DIR_LSB + g];
        assign pinOutBase[g] = ioCtrl_r[amcgr_pkg::IO_DIR_LSB + g] &
                               ioCtrl_r[amcgr_pkg::IO_DATA_LSB + g];
    end

    // shared pin drive; the overrides sit last so they win over the direction bits
    always_comb begin
        gpioOe_nxt = pinOeBase;
        gpioOut_nxt = pinOutBase;
        if (auxCtrl_r[amcgr_pkg::AUX_STBY_BIT]) begin
            gpioOe_nxt[amcgr_pkg::PIN_STBY] = 1'b1;
            gpioOut_nxt[amcgr_pkg::PIN_STBY] = (cif.state == amcgr_pkg::ST_STANDBY);
        end
        if (auxCtrl_r[amcgr_pkg::AUX_INTSEL_BIT]) begin
            gpioOe_nxt[amcgr_pkg::PIN_INT] = 1'b1;
            gpioOut_nxt[amcgr_pkg::PIN_INT] = ready_r;
        end
        // the pin is an input for both external selections, so it is never driven then
        clkOe_nxt = (cif.clkSel == amcgr_pkg::CLK_INT_OUT);
        clkOut_nxt = clkOe_nxt & cif.intClkLvl;
        filtRst_nxt = cif.filterHold;
        stby_nxt = (cif.state == amcgr_pkg::ST_STANDBY);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gpioOut_r <= 4'h0;
            gpioOe_r <= 4'h0;
            clkOut_r <= 1'b0;
            clkOe_r <= 1'b0;
            filtRst_r <= 1'b1;
            stby_r <= 1'b0;
        end else begin
            gpioOut_r <= gpioOut_nxt;
            gpioOe_r <= gpioOe_nxt;
            clkOut_r <= clkOut_nxt;
            clkOe_r <= clkOe_nxt;
            filtRst_r <= filtRst_nxt;
            stby_r <= stby_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign gpioOut = gpioOut_r;
    assign gpioOe = gpioOe_r;
    assign clkPinOut = clkOut_r;
    assign clkPinOe = clkOe_r;
    assign filterReset = filtRst_r;
    assign standbyActive = stby_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_sync_idle;
        (cif.resultLoad && cif.mode == amcgr_pkg::MODE_SYNC_IDLE) |->
            (cif.state == amcgr_pkg::ST_IDLE) ##1 (filterReset && !standbyActive);
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("no idle after sequence");

    property p_sync_stby;
        (cif.resultLoad && cif.mode == amcgr_pkg::MODE_SYNC_STBY) |->
            (cif.state == amcgr_pkg::ST_STANDBY) ##1 standbyActive;
    endproperty
    a_sync_stby: assert property (p_sync_stby) else $error("no standby after sequence");

    property p_clksel_write;
        hit(regWrEn, regAddr, amcgr_pkg::ADDR_CONV_CONTROL) ##1 regRdEn &&
            regAddr == amcgr_pkg::ADDR_CONV_CONTROL && !regWrEn |=>
            regRdData[1:0] == $past(regWrData[1:0], 2);
    endproperty
    a_clksel_write: assert property (p_clksel_write) else $error("clock select readback");

    property p_int_quiet;
        (cif.clkSel == amcgr_pkg::CLK_INT_OFF) |=> !clkPinOe && !clkPinOut;
    endproperty
    a_int_quiet: assert property (p_int_quiet) else $error("clock pin driven in 00");

    property p_int_out;
        (cif.clkSel == amcgr_pkg::CLK_INT_OUT) |=>
            clkPinOe && (clkPinOut == $past(cif.intClkLvl));
    endproperty
    a_int_out: assert property (p_int_out) else $error("clock pin not following osc");

    property p_result_ro;
        (hit(regWrEn, regAddr, amcgr_pkg::ADDR_RESULT) && !cif.resultLoad) |=>
            $stable(result_r);
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result changed by write");

    property p_result_read;
        hit(regRdEn, regAddr, amcgr_pkg::ADDR_RESULT) |=> regRdData == $past(result_r);
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read mismatch");

    property p_gpo_drive;
        (!auxCtrl_r[0] && ioCtrl_r[3]) |=> gpioOe[3] && (gpioOut[3] == $past(ioCtrl_r[7]));
    endproperty
    a_gpo_drive: assert property (p_gpo_drive) else $error("pin four level wrong");

    property p_dir_input;
        (!ioCtrl_r[0]) |=> !gpioOe[0];
    endproperty
    a_dir_input: assert property (p_dir_input) else $error("pin one driven as input");

    property p_stby_pin;
        auxCtrl_r[0] |=> gpioOe[3] && (gpioOut[3] == $past(cif.state == amcgr_pkg::ST_STANDBY));
    endproperty
    a_stby_pin: assert property (p_stby_pin) else $error("standby override lost");

    property p_int_pin;
        auxCtrl_r[1] |=> gpioOe[1] && (gpioOut[1] == $past(ready_r));
    endproperty
    a_int_pin: assert property (p_int_pin) else $error("interrupt override lost");

    property p_io_reserved;
        hit(regRdEn, regAddr, amcgr_pkg::ADDR_IO_CONTROL) |=> regRdData[15:8] == 8'h00;
    endproperty
    a_io_reserved: assert property (p_io_reserved) else $error("reserved bits not zero");

    property p_io_reset;
        @(posedge mclk) disable iff (1'b0) sys_rst |=> (ioCtrl_r == 8'h00) && (gpioOe == 4'h0);
    endproperty
    a_io_reset: assert property (p_io_reset) else $error("pin control not reset");

    property p_idle_hold;
        (cif.state == amcgr_pkg::ST_IDLE) [*2] |=> filterReset;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("filter not held in idle");

    property p_ext_tick;
        (cif.clkSel == amcgr_pkg::CLK_EXT && $rose(extClkIn)) |=> cif.modTick;
    endproperty
    a_ext_tick: assert property (p_ext_tick) else $error("external edge lost");

    property p_ext_quiet;
        (cif.clkSel == amcgr_pkg::CLK_EXT || cif.clkSel == amcgr_pkg::CLK_EXT_DIV2) |=>
            !clkPinOe && !clkPinOut;
    endproperty
    a_ext_quiet: assert property (p_ext_quiet) else $error("pin driven");

    property p_result_load;
        cif.resultLoad |=> result_r == $past(modResult);
    endproperty
    a_result_load: assert property (p_result_load) else $error("result not loaded");

    property p_dir_map;
        (auxCtrl_r == 2'b00) |=> gpioOe == $past(ioCtrl_r[3:0]);
    endproperty
    a_dir_map: assert property (p_dir_map) else $error("direction map wrong");

    property p_data_map;
        (auxCtrl_r == 2'b00) |=> gpioOut == $past(ioCtrl_r[7:4] & ioCtrl_r[3:0]);
    endproperty
    a_data_map: assert property (p_data_map) else $error("pin levels wrong");

    property p_convert_run;
        (cif.state == amcgr_pkg::ST_CONVERT) [*2] |=> !filterReset;
    endproperty
    a_convert_run: assert property (p_convert_run) else $error("filter held");

    property p_stby_rest;
        (cif.mode == amcgr_pkg::MODE_SYNC_STBY && cif.state != amcgr_pkg::ST_CONVERT) |=>
            cif.state != amcgr_pkg::ST_IDLE;
    endproperty
    a_stby_rest: assert property (p_stby_rest) else $error("rested in idle");

    property p_idle_rest;
        (cif.mode == amcgr_pkg::MODE_SYNC_IDLE && cif.state != amcgr_pkg::ST_CONVERT) |=>
            cif.state != amcgr_pkg::ST_STANDBY;
    endproperty
    a_idle_rest: assert property (p_idle_rest) else $error("rested in standby");

    property p_sync_hold;
        (cif.mode == amcgr_pkg::MODE_SYNC_IDLE || cif.mode == amcgr_pkg::MODE_SYNC_STBY) &&
            cif.state == amcgr_pkg::ST_CONVERT && !cif.modTick |=>
            cif.state == amcgr_pkg::ST_CONVERT;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sequence cut short");

    property p_ready_set;
        cif.resultLoad |=> ready_r;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("data ready not set");

    property p_ready_clear;
        (hit(regRdEn, regAddr, amcgr_pkg::ADDR_RESULT) && !cif.resultLoad) |=> !ready_r;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("data ready stuck");

    property p_stby_status;
        (cif.state == amcgr_pkg::ST_STANDBY) |=> standbyActive;
    endproperty
    a_stby_status: assert property (p_stby_status) else $error("standby flag lost");

    c_sync_idle: cover property (cif.resultLoad && cif.mode == amcgr_pkg::MODE_SYNC_IDLE);
    c_sync_stby: cover property (cif.resultLoad && cif.mode == amcgr_pkg::MODE_SYNC_STBY);
    c_div2_tick: cover property (cif.clkSel == amcgr_pkg::CLK_EXT_DIV2 && cif.modTick);
    c_stby_pin: cover property (auxCtrl_r[0] && gpioOut[3]);
    c_ext_tick: cover property (cif.clkSel == amcgr_pkg::CLK_EXT && cif.modTick);
endmodule

// file: verilog/amcgr_seq.sv
// sync pin driven conversion sequencer
`timescale 1ns/1ps
module amcgr_seq (
    input wire logic mclk,
    input wire logic sysRst,
    input wire logic syncPinIn,
    amcgr_core_if.seq cif
);
    logic syncMeta_r, syncLvl_r, syncPrev_r;
    amcgr_pkg::amcgr_state_t state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic load_r, load_nxt;
    logic hold_r;
    logic syncFall;
    logic syncMode;

    function automatic amcgr_pkg::amcgr_state_t restState(input logic [3:0] m);
        if (m == amcgr_pkg::MODE_SYNC_STBY || m == amcgr_pkg::MODE_STANDBY) begin
            restState = amcgr_pkg::ST_STANDBY;
        end else begin
            restState = amcgr_pkg::ST_IDLE;
        end
    endfunction

    // the second and third stages feed the edge detector, never the first
    assign syncFall = syncPrev_r & ~syncLvl_r;
    assign syncMode = (cif.mode == amcgr_pkg::MODE_SYNC_IDLE) ||
                      (cif.mode == amcgr_pkg::MODE_SYNC_STBY);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        load_nxt = 1'b0;
        case (state_r)
            amcgr_pkg::ST_CONVERT: begin
                if (!syncMode) begin
                    state_nxt = restState(cif.mode);
                end else if (cif.modTick) begin
                    if (cnt_r == amcgr_pkg::CONV_TICKS - 8'h01) begin
                        load_nxt = 1'b1;
                        state_nxt = restState(cif.mode);
                    end else begin
                        cnt_nxt = cnt_r + 8'h01;
                    end
                end
            end
            amcgr_pkg::ST_IDLE, amcgr_pkg::ST_STANDBY: begin
                if (syncMode && syncFall) begin
                    state_nxt = amcgr_pkg::ST_CONVERT;
                    cnt_nxt = 8'h00;
                end else begin
                    state_nxt = restState(cif.mode);
                end
            end
            default: state_nxt = amcgr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sysRst) begin
            syncMeta_r <= 1'b1;
            syncLvl_r <= 1'b1;
            syncPrev_r <= 1'b1;
            state_r <= amcgr_pkg::ST_IDLE;
            cnt_r <= 8'h00;
            load_r <= 1'b0;
            hold_r <= 1'b1;
        end else begin
            syncMeta_r <= syncPinIn;
            syncLvl_r <= syncMeta_r;
            syncPrev_r <= syncLvl_r;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            load_r <= load_nxt;
            hold_r <= (state_nxt != amcgr_pkg::ST_CONVERT);
        end
    end

    assign cif.state = state_r;
    assign cif.resultLoad = load_r;
    assign cif.filterHold = hold_r;

    property p_sync_start;
        @(posedge mclk) disable iff (sysRst)
        (syncMode && syncFall && state_r != amcgr_pkg::ST_CONVERT) |=>
            (state_r == amcgr_pkg::ST_CONVERT);
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("sync edge did not start");
endmodule
